/* File: rxpcs_pkg.sv */
// rxpcs_pkg: constants, register map and states for the receive pcs control block
package rxpcs_pkg;
  // lane geometry
  localparam int LANES_DEF     = 20;
  localparam int ERR_W         = 4;
  localparam int HDR_W         = 2;
  // 64b/66b sync header patterns that count as legal
  localparam logic [1:0] HDR_DATA = 2'h1;
  localparam logic [1:0] HDR_CTRL = 2'h2;
  // timing in cycles of the 100 MHz clock
  localparam int REPORT_CYCLES  = 8;
  localparam int LOCK_GOOD      = 64;
  localparam int REALIGN_CYCLES = 16;
  localparam int CNT_W          = 8;
  // avalon register byte offsets
  localparam logic [4:0] OFS_CTRL     = 5'h00;
  localparam logic [4:0] OFS_STATUS   = 5'h04;
  localparam logic [4:0] OFS_INT_STAT = 5'h08;
  localparam logic [4:0] OFS_INT_CLR  = 5'h0C;
  localparam logic [4:0] OFS_INT_EN   = 5'h10;
  localparam logic [4:0] OFS_LOCKED   = 5'h14;
  // control fields
  localparam int CTRL_SW_EN_BIT  = 0;
  localparam int CTRL_REALIGN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  // status fields
  localparam int ST_ALIGNED_BIT = 0;
  localparam int ST_ACTIVE_BIT  = 1;
  localparam int ST_INPKT_BIT   = 2;
  localparam int ST_STOPPED_BIT = 3;
  // interrupt event bits
  localparam int EV_W           = 3;
  localparam int EV_ALIGNED     = 0;
  localparam int EV_FRAME_ERR   = 1;
  localparam int EV_STOPPED     = 2;
  localparam logic [2:0] INT_EN_RESET = 3'h0;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0;
  typedef enum logic [1:0] {ALN_REALIGN, ALN_HUNT, ALN_RUN} rxpcs_aln_t;
endpackage

/* File: rxpcs_ctrl.sv */
// rxpcs_ctrl: receive enable gating, forced realign and per-lane framing error stats
//
// Implementation choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - enable low: finish current packet, then stop decoding and accepting.
// - while disabled: no statistics reported, local packet bus idle.
// - force realign high resets path, relocks lanes, realigns; low runs normally.
// - each lane drives its own four-bit sync header error count.
// - a lane count means something only while its valid bit is high.
// - counts may change in any cycle, no fixed schedule promised.
// - count outputs exist for lanes zero to seventeen, same format.
// - lanes eighteen and nineteen too: twenty lanes, each with valid.
module rxpcs_ctrl
  import rxpcs_pkg::*;
#(
  parameter int LANES  = LANES_DEF,
  parameter int DATA_W = 64
) (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     rstn,
  // control from user logic
  input  wire logic                     rx_path_enable,
  input  wire logic                     rx_force_realign,
  // sync headers per lane from the gearbox
  input  wire logic [LANES-1:0]         lane_hdr_valid,
  input  wire logic [LANES*HDR_W-1:0]   lane_hdr,
  // decoded packet stream
  input  wire logic                     dec_valid,
  input  wire logic                     dec_sop,
  input  wire logic                     dec_eop,
  input  wire logic [DATA_W-1:0]        dec_data,
  // local packet bus
  output logic                          local_packet_bus_valid,
  output logic                          local_packet_bus_sop,
  output logic                          local_packet_bus_eop,
  output logic [DATA_W-1:0]             local_packet_bus_data,
  // framing error statistics
  output logic [LANES*ERR_W-1:0]        framing_err_count,
  output logic [LANES-1:0]              framing_err_valid,
  // status
  output logic                          rx_aligned,
  output logic                          decode_enable,
  // avalon-mm slave
  input  wire logic [4:0]               avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  output logic [31:0]                   avs_readdata,
  output logic                          avs_waitrequest,
  // interrupt
  output logic                          irq
);

  function automatic logic hdr_bad(input logic [1:0] h);
    hdr_bad = (h != HDR_DATA) && (h != HDR_CTRL);
  endfunction

  rxpcs_aln_t                aln_reg;
  logic [CNT_W-1:0]          aln_cnt_reg;
  logic [LANES-1:0]          lock_reg;
  logic [CNT_W-1:0]          good_cnt_reg [LANES];
  logic [ERR_W-1:0]          acc_reg [LANES];
  logic [LANES-1:0]          seen_reg;
  logic [CNT_W-1:0]          win_cnt_reg;
  logic                      in_pkt_reg;
  logic                      stopped_reg;
  logic [1:0]                ctrl_reg;
  logic [EV_W-1:0]           int_stat_reg;
  logic [EV_W-1:0]           int_en_reg;
  logic                      ack_reg;
  logic                      realign_req;
  logic                      rx_on;
  logic                      start_ok;
  logic                      beat_take;
  logic                      win_end;
  logic                      any_err;
  logic [EV_W-1:0]           ev_set;
  logic                      req;
  logic                      wr_take;
  logic                      rd_take;

  // software realign ORs into the pin so either source can restart alignment
  assign realign_req = rx_force_realign | ctrl_reg[CTRL_REALIGN_BIT];
  assign rx_on       = rx_path_enable & ctrl_reg[CTRL_SW_EN_BIT];
  assign rx_aligned  = (aln_reg == ALN_RUN);
  // decoding is frozen once stopped; a packet in flight keeps it running
  assign decode_enable = ~stopped_reg;
  assign start_ok    = rx_on & rx_aligned;
  assign beat_take   = dec_valid & rx_aligned &
                       (in_pkt_reg | (dec_sop & start_ok));
  assign win_end     = (win_cnt_reg == CNT_W'(REPORT_CYCLES - 1));

  // alignment sequencer
  always_ff @(posedge clock) begin
    if (!rstn) begin
      aln_reg     <= ALN_REALIGN;
      aln_cnt_reg <= '0;
    end else if (realign_req) begin
      aln_reg     <= ALN_REALIGN;
      aln_cnt_reg <= '0;
    end else begin
      case (aln_reg)
        ALN_REALIGN: begin
          aln_cnt_reg <= aln_cnt_reg + CNT_W'(1);
          if (aln_cnt_reg == CNT_W'(REALIGN_CYCLES - 1)) begin
            aln_reg <= ALN_HUNT;
          end
        end
        ALN_HUNT: begin
          if (&lock_reg) begin
            aln_reg <= ALN_RUN;
          end
        end
        ALN_RUN: begin
          if (!(&lock_reg)) begin
            aln_reg <= ALN_HUNT;
          end
        end
        default: aln_reg <= ALN_REALIGN;
      endcase
    end
  end

  // per-lane header lock: consecutive legal headers, any bad header drops it
  always_ff @(posedge clock) begin
    if (!rstn) begin
      lock_reg <= '0;
      for (int i = 0; i < LANES; i++) begin
        good_cnt_reg[i] <= '0;
      end
    end else if (realign_req || aln_reg == ALN_REALIGN || stopped_reg) begin
      lock_reg <= '0;
      for (int i = 0; i < LANES; i++) begin
        good_cnt_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < LANES; i++) begin
        if (lane_hdr_valid[i]) begin
          if (hdr_bad(lane_hdr[i*HDR_W +: HDR_W])) begin
            good_cnt_reg[i] <= '0;
            lock_reg[i]     <= 1'b0;
          end else if (good_cnt_reg[i] == CNT_W'(LOCK_GOOD - 1)) begin
            lock_reg[i] <= 1'b1;
          end else begin
            good_cnt_reg[i] <= good_cnt_reg[i] + CNT_W'(1);
          end
        end
      end
    end
  end

  // packet gate: enable drop lets the current packet end, then stops
  always_ff @(posedge clock) begin
    if (!rstn) begin
      in_pkt_reg  <= 1'b0;
      stopped_reg <= 1'b1;
    end else begin
      if (realign_req || !rx_aligned) begin
        in_pkt_reg <= 1'b0;
      end else if (beat_take) begin
        in_pkt_reg <= ~dec_eop;
      end
      if (rx_on) begin
        stopped_reg <= 1'b0;
      end else if (!in_pkt_reg || (beat_take && dec_eop)) begin
        stopped_reg <= 1'b1;
      end
    end
  end

  // local packet bus register; idle whenever nothing is taken
  always_ff @(posedge clock) begin
    if (!rstn) begin
      local_packet_bus_valid <= 1'b0;
      local_packet_bus_sop   <= 1'b0;
      local_packet_bus_eop   <= 1'b0;
      local_packet_bus_data  <= '0;
    end else begin
      local_packet_bus_valid <= beat_take;
      local_packet_bus_sop   <= beat_take & dec_sop;
      local_packet_bus_eop   <= beat_take & dec_eop;
      local_packet_bus_data  <= beat_take ? dec_data : '0;
    end
  end

  // report window; window shorter than 16 keeps the 4-bit count from wrapping
  always_ff @(posedge clock) begin
    if (!rstn || stopped_reg) begin
      win_cnt_reg <= '0;
    end else if (win_end) begin
      win_cnt_reg <= '0;
    end else begin
      win_cnt_reg <= win_cnt_reg + CNT_W'(1);
    end
  end

  // per-lane error accumulation and reporting
  always_ff @(posedge clock) begin
    if (!rstn || stopped_reg) begin
      seen_reg          <= '0;
      framing_err_count <= '0;
      framing_err_valid <= '0;
      for (int i = 0; i < LANES; i++) begin
        acc_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < LANES; i++) begin
        logic [ERR_W-1:0] sum;
        logic             hit;
        sum = '0;
        hit = 1'b0;
        hit = lane_hdr_valid[i];
        sum = acc_reg[i] +
              ERR_W'(hit & hdr_bad(lane_hdr[i*HDR_W +: HDR_W]));
        if (win_end) begin
          framing_err_count[i*ERR_W +: ERR_W] <= sum;
          framing_err_valid[i] <= seen_reg[i] | hit;
          acc_reg[i]  <= '0;
          seen_reg[i] <= 1'b0;
        end else begin
          framing_err_valid[i] <= 1'b0;
          acc_reg[i]  <= sum;
          seen_reg[i] <= seen_reg[i] | hit;
        end
      end
    end
  end

  assign any_err = |framing_err_count;

  assign ev_set[EV_ALIGNED]   = (aln_reg == ALN_HUNT) & (&lock_reg) & ~realign_req;
  assign ev_set[EV_FRAME_ERR] = (|framing_err_valid) & any_err;
  assign ev_set[EV_STOPPED]   = ~stopped_reg & ~rx_on &
                                (~in_pkt_reg | (beat_take & dec_eop));

  // avalon slave: one wait cycle, then answer
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_reg;
  assign wr_take         = avs_write & ack_reg;
  assign rd_take         = avs_read & ~ack_reg;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctrl_reg   <= CTRL_RESET;
      int_en_reg <= INT_EN_RESET;
    end else begin
      // realign bit self-clears so a write acts as a one-cycle pulse
      ctrl_reg[CTRL_REALIGN_BIT] <= 1'b0;
      if (wr_take && avs_address == OFS_CTRL) begin
        ctrl_reg <= avs_writedata[1:0];
      end
      if (wr_take && avs_address == OFS_INT_EN) begin
        int_en_reg <= avs_writedata[EV_W-1:0];
      end
    end
  end

  // sticky events: a set in the clearing cycle survives
  always_ff @(posedge clock) begin
    if (!rstn) begin
      int_stat_reg <= '0;
    end else if (wr_take && avs_address == OFS_INT_CLR) begin
      int_stat_reg <= (int_stat_reg & ~avs_writedata[EV_W-1:0]) | ev_set;
    end else begin
      int_stat_reg <= int_stat_reg | ev_set;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      avs_readdata <= '0;
    end else if (rd_take) begin
      case (avs_address)
        OFS_CTRL:     avs_readdata <= {30'h0, ctrl_reg};
        OFS_STATUS:   avs_readdata <= {28'h0, stopped_reg, in_pkt_reg,
                                       ~stopped_reg, rx_aligned};
        OFS_INT_STAT: avs_readdata <= {29'h0, int_stat_reg};
        OFS_INT_EN:   avs_readdata <= {29'h0, int_en_reg};
        OFS_LOCKED:   avs_readdata <= 32'(lock_reg);
        default:      avs_readdata <= UNMAPPED_DATA;
      endcase
    end
  end

  assign irq = |(int_stat_reg & int_en_reg);

endmodule

`default_nettype wire

/* File: rxpcs_ctrl_monitor.sv */
// checker of the receive control block port behaviour
`timescale 1ns/1ps
`default_nettype none
module rxpcs_ctrl_monitor
  import rxpcs_pkg::*;
#(
  parameter int LANES  = LANES_DEF,
  parameter int DATA_W = 64
) (
  // clock and reset
  input wire logic                   clock,
  input wire logic                   rstn,
  // inputs watched
  input wire logic                   rx_path_enable,
  input wire logic                   rx_force_realign,
  input wire logic                   dec_valid,
  input wire logic                   dec_sop,
  input wire logic [DATA_W-1:0]      dec_data,
  // outputs watched
  input wire logic                   local_packet_bus_valid,
  input wire logic                   local_packet_bus_sop,
  input wire logic [DATA_W-1:0]      local_packet_bus_data,
  input wire logic [LANES*ERR_W-1:0] framing_err_count,
  input wire logic [LANES-1:0]       framing_err_valid,
  input wire logic                   rx_aligned,
  input wire logic                   decode_enable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_quiet; (framing_err_valid == '0) [*7]; endsequence
  sequence s_lost; !rx_aligned [*8]; endsequence
  // the last beat may leave in the cycle the stop is decided, so allow one cycle
  property p_bus_idle; !decode_enable && !$past(decode_enable) |-> !local_packet_bus_valid;
  endproperty
  property p_no_stats; !decode_enable && !$past(decode_enable) |-> framing_err_valid == '0;
  endproperty
  property p_pulse; |framing_err_valid |=> s_quiet; endproperty
  property p_cnt_lo; framing_err_valid[0] |-> framing_err_count[ERR_W-1:0] <= REPORT_CYCLES;
  endproperty
  property p_cnt_hi; framing_err_valid[LANES-1]
    |-> framing_err_count[LANES*ERR_W-1 -: ERR_W] <= REPORT_CYCLES; endproperty
  property p_pkt; local_packet_bus_valid |-> $past(dec_valid) && $past(rx_aligned)
    && local_packet_bus_data == $past(dec_data) && local_packet_bus_sop == $past(dec_sop);
  endproperty
  property p_stay_off; !rx_path_enable && !decode_enable |=> !decode_enable; endproperty
  property p_realign; rx_force_realign |=> s_lost; endproperty
  a_bus_idle: assert property (p_bus_idle) else $error("packet bus busy while off");
  a_no_stats: assert property (p_no_stats) else $error("stats while off");
  a_pulse: assert property (p_pulse) else $error("stat valid too often");
  a_cnt_lo: assert property (p_cnt_lo) else $error("lane 0 count too big");
  a_cnt_hi: assert property (p_cnt_hi) else $error("lane 19 count too big");
  a_pkt: assert property (p_pkt) else $error("beat out without beat in");
  a_stay_off: assert property (p_stay_off) else $error("decode resumed");
  a_realign: assert property (p_realign) else $error("kept alignment");
endmodule
bind rxpcs_ctrl rxpcs_ctrl_monitor #(.LANES(LANES), .DATA_W(DATA_W)) i_rxpcs_ctrl_monitor (
  .clock, .rstn, .rx_path_enable, .rx_force_realign, .dec_valid, .dec_sop, .dec_data,
  .local_packet_bus_valid, .local_packet_bus_sop, .local_packet_bus_data,
  .framing_err_count, .framing_err_valid, .rx_aligned, .decode_enable);
`default_nettype wire

/* File: rxpcs_lane_model.sv */
// link partner model: lane sync headers and decoded packet beats
`timescale 1ns/1ps
`default_nettype none
module rxpcs_lane_model
  import rxpcs_pkg::*;
#(
  parameter int LANES  = LANES_DEF,
  parameter int DATA_W = 64
) (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rstn,
  // scenario control
  input  wire logic [LANES-1:0]       bad_lanes,
  input  wire logic                   pkt_go,
  input  wire logic [7:0]             pkt_len,
  // toward the block
  output logic [LANES-1:0]            lane_hdr_valid,
  output logic [LANES*HDR_W-1:0]      lane_hdr,
  output logic                        dec_valid,
  output logic                        dec_sop,
  output logic                        dec_eop,
  output logic [DATA_W-1:0]           dec_data
);
  logic [7:0] left_reg;
  logic       first_reg;
  logic [7:0] ph_reg;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      left_reg <= 8'h0;
      first_reg <= 1'b0;
      ph_reg <= 8'h0;
    end else begin
      ph_reg <= ph_reg + 8'h1;
      first_reg <= pkt_go;
      if (pkt_go) begin
        left_reg <= pkt_len;
      end else if (left_reg != 8'h0) begin
        left_reg <= left_reg - 8'h1;
      end
    end
  end
  // bad lanes alternate both illegal patterns, good lanes both legal ones
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      lane_hdr[i*HDR_W +: HDR_W] = bad_lanes[i] ? {2{ph_reg[0]}}
        : (ph_reg[0] ? HDR_DATA : HDR_CTRL);
    end
  end
  assign lane_hdr_valid = '1;
  assign dec_valid = left_reg != 8'h0;
  assign dec_sop   = dec_valid && first_reg;
  assign dec_eop   = left_reg == 8'h1;
  // data changes every cycle, so a stale copy never passes for a fresh beat
  assign dec_data  = {(DATA_W/8){ph_reg}};
endmodule
`default_nettype wire

/* File: tb_rx_pcs_control_framing_stats.sv */
// self-checking testbench for the receive control and framing stats block
`timescale 1ns/1ps
`default_nettype none
module tb_rx_pcs_control_framing_stats
  import rxpcs_pkg::*;
();
  logic clock = 0, rstn = 0, rx_path_enable = 1, rx_force_realign = 0, pkt_go = 0;
  logic [19:0] bad_lanes = 0, lane_hdr_valid, framing_err_valid;
  logic [39:0] lane_hdr;
  logic [79:0] framing_err_count;
  logic [7:0] pkt_len = 0;
  logic [63:0] dec_data, local_packet_bus_data;
  logic dec_valid, dec_sop, dec_eop, local_packet_bus_valid, local_packet_bus_sop;
  logic local_packet_bus_eop, rx_aligned, decode_enable, avs_waitrequest, irq;
  logic avs_read = 0, avs_write = 0;
  logic [4:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, rdat, m;
  int num_errors = 0, comparisons = 0, seed = 50, cyc = 0, beats = 0, eops = 0;
  rxpcs_ctrl i_rxpcs_ctrl (.clock, .rstn, .rx_path_enable, .rx_force_realign,
    .lane_hdr_valid, .lane_hdr, .dec_valid, .dec_sop, .dec_eop, .dec_data,
    .local_packet_bus_valid, .local_packet_bus_sop, .local_packet_bus_eop,
    .local_packet_bus_data, .framing_err_count, .framing_err_valid, .rx_aligned,
    .decode_enable, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .irq);
  rxpcs_lane_model i_rxpcs_lane_model (.clock, .rstn, .bad_lanes, .pkt_go, .pkt_len,
    .lane_hdr_valid, .lane_hdr, .dec_valid, .dec_sop, .dec_eop, .dec_data);
  always #5 clock = ~clock;
  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    beats <= beats + (local_packet_bus_valid === 1'b1);
    eops <= eops + (local_packet_bus_eop === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (e !== s) begin
      num_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic realign();
    int n;
    n = 0;
    bad_lanes <= '0;
    rx_force_realign <= 1'b1;
    tick(1);
    rx_force_realign <= 1'b0;
    tick(2);
    chk("realigning", 0, rx_aligned);
    while (rx_aligned !== 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    chk("aligned", 1, rx_aligned);
    bus(0, OFS_LOCKED, 0);
    chk("locked", 32'hFFFFF, rdat);
  endtask
  // packet of len beats; cut > 0 drops the enable that many cycles after sop
  task automatic packet(input logic [7:0] len, input int cut, input int expn);
    int b0;
    int e0;
    b0 = beats;
    e0 = eops;
    pkt_go <= 1'b1;
    pkt_len <= len;
    tick(1);
    pkt_go <= 1'b0;
    if (cut > 0) begin
      tick(cut);
      rx_path_enable <= 1'b0;
    end
    tick(len + 4);
    chk("beats", b0 + expn, beats);
    chk("eops", e0 + (expn > 0), eops);
  endtask
  function automatic int exp_sum(input logic b, input int n);
    return b ? n * REPORT_CYCLES : 0;
  endfunction
  task automatic pulse();
    do @(posedge clock); while (framing_err_valid[0] !== 1'b1);
  endtask
  // first two reports may straddle the mask change, the next three are summed
  task automatic stats(input logic [19:0] msk);
    int sum [LANES_DEF];
    bad_lanes <= msk;
    pulse();
    pulse();
    sum = '{default: 0};
    repeat (3) begin
      pulse();
      for (int i = 0; i < LANES_DEF; i++) begin
        if (framing_err_valid[i] === 1'b1) sum[i] += framing_err_count[i*ERR_W +: ERR_W];
      end
    end
    for (int i = 0; i < LANES_DEF; i++) chk("lane_sum", exp_sum(msk[i], 3), sum[i]);
  endtask
  initial begin
    tick(12);
    rstn <= 1'b1;
    bus(0, OFS_CTRL, 0);
    chk("ctrl", {30'h0, CTRL_RESET}, rdat);
    bus(0, OFS_INT_EN, 0);
    chk("int_en", {29'h0, INT_EN_RESET}, rdat);
    bus(0, 5'h18, 0);
    chk("unmapped", UNMAPPED_DATA, rdat);
    bus(1, OFS_INT_EN, 32'h2);
    bus(0, OFS_INT_EN, 0);
    chk("int_en", 32'h2, rdat);
    realign();
    packet(8'h5, 0, 5);
    packet(8'h6, 2, 6);
    chk("decode_enable", 0, decode_enable);
    bus(0, OFS_STATUS, 0);
    chk("st_stopped", 1, rdat[ST_STOPPED_BIT]);
    chk("st_active", 0, rdat[ST_ACTIVE_BIT]);
    bus(0, OFS_INT_STAT, 0);
    chk("ev_stopped", 1, rdat[EV_STOPPED]);
    chk("ev_aligned", 1, rdat[EV_ALIGNED]);
    tick(20);
    packet(8'h4, 0, 0);
    rx_path_enable <= 1'b1;
    stats(20'hFFFFF);
    chk("irq", 1, irq);
    stats(20'h80000);
    stats(20'h0);
    bus(1, OFS_INT_CLR, 32'h7);
    bus(0, OFS_INT_STAT, 0);
    chk("int_stat", 0, rdat[EV_FRAME_ERR]);
    chk("irq", 0, irq);
    bus(1, OFS_INT_EN, 32'h0);
    stats(20'h00001);
    chk("irq_masked", 0, irq);
    bus(0, OFS_INT_STAT, 0);
    chk("int_stat", 1, rdat[EV_FRAME_ERR]);
    repeat (3) begin
      m = $random(seed);
      stats(m[19:0]);
      realign();
      packet(8'h1 + m[22:20], 0, 1 + m[22:20]);
    end
    finish_test();
  end
endmodule
`default_nettype wire
